//--- rtl/rss_pkg.sv
package rss_pkg;

  // ****************************************
  // Clock and timing
  // ****************************************
  localparam int CLK_PERIOD_NS   = 20;
  localparam int POR_DELAY_NS    = 300000;  // Release delay after supply is good
  localparam int MCD_TIMEOUT_NS  = 100000;  // Missing clock one-shot period
  // Longest time rounds down, least time rounds up
  localparam int POR_DELAY_CYC   = POR_DELAY_NS / CLK_PERIOD_NS;
  localparam int MCD_TIMEOUT_CYC = (MCD_TIMEOUT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int SETTLE_CYC      = 4;       // Pin settling after drive release
  localparam int CNT_W           = 16;

  // ****************************************
  // Register map and fields
  // ****************************************
  localparam logic [7:0] CAUSE_ADDR     = 8'h00;  // reset_cause_register
  localparam logic [7:0] SMON_ADDR      = 8'h01;  // Supply monitor control
  localparam int         PIN_FLAG_BIT   = 0;
  localparam int         POR_FLAG_BIT   = 1;
  localparam int         MCD_FLAG_BIT   = 2;
  localparam int         SMON_EN_BIT    = 7;
  localparam int         SMON_STAT_BIT  = 6;
  localparam logic       SMON_EN_RST    = 1'b1;
  localparam logic       SMON_SEL_RST   = 1'b1;
  localparam logic       MCD_EN_RST     = 1'b0;
  localparam logic [7:0] PORT_PARK_VAL  = 8'hFF;
  localparam logic [3:0] WDT_DIV_VAL    = 4'hC;
  localparam logic [7:0] RD_ZERO        = 8'h00;

  // ****************************************
  // States and causes
  // ****************************************
  typedef enum logic [4:0] {
    ST_POR_WAIT  = 5'b00001,
    ST_POR_DELAY = 5'b00010,
    ST_HOLD      = 5'b00100,
    ST_SETTLE    = 5'b01000,
    ST_RUN       = 5'b10000
  } rss_state_type;

  typedef enum logic [3:0] {
    CS_POR = 4'b0001,
    CS_SUP = 4'b0010,
    CS_PIN = 4'b0100,
    CS_MCD = 4'b1000
  } rss_cause_type;

endpackage : rss_pkg

//--- rtl/rss_sync.sv
`timescale 1ns/100ps
module rss_sync #(
  parameter logic RST_VAL = 1'b0
) (
  // Clock and asynchronous reset to RST_VAL
  input  wire logic clk,
  input  wire logic arst,
  // Data
  input  wire logic d,
  output logic      q
);

  logic meta_q;

  // Two stages; the first is read only by the second
  always_ff @(posedge clk or posedge arst) begin
    if (arst) begin
      meta_q <= RST_VAL;
      q      <= RST_VAL;
    end else begin
      meta_q <= d;
      q      <= meta_q;
    end
  end

endmodule : rss_sync

//--- rtl/rss_top.sv
// Strobed register access and the placing of the registers were decided locally.
`timescale 1ns/100ps
module rss_top
  import rss_pkg::*;
#(
  parameter int POR_DELAY_CYCLES   = POR_DELAY_CYC,
  parameter int MCD_TIMEOUT_CYCLES = MCD_TIMEOUT_CYC
) (
  // Clock and power-on reset
  input  wire logic       sys_clk,
  input  wire logic       rst,
  // Reset request sources
  input  wire logic       supply_low_in,
  input  wire logic       rst_pin_n_in,
  input  wire logic       sysclk_probe_in,
  // Reset pin drive
  output logic            rst_pin_out_q,
  output logic            rst_pin_oe_q,
  // Register port
  input  wire logic [7:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  input  wire logic       reg_wr,
  input  wire logic       reg_rd,
  output logic [7:0]      reg_rdata_q,
  // Core and system controls
  output logic            core_reset_q,
  output logic            sfr_load_q,
  output logic            irq_tmr_off_q,
  output logic            sp_init_q,
  output logic [7:0]      port_latch_q,
  output logic            port_od_q,
  output logic            pullup_q,
  output logic            pc_zero_q,
  output logic            clk_int_q,
  output logic            wdt_start_q,
  output logic [3:0]      wdt_div_q
);

  // ****************************************
  // Declarations
  // ****************************************
  rss_state_type    state_q, state_d;
  rss_cause_type    cause_q, cause_d;
  logic [CNT_W-1:0] cnt_q;
  logic [CNT_W-1:0] idle_cnt_q;
  logic             pin_req, sup_req, sup_low_s, probe_s, probe_q;
  logic             pin_mask_q;
  logic             pin_arst, sup_arst, async_req;
  logic             mcd_trip;
  logic             release_d, in_reset_d;
  logic             pin_flag_q, por_flag_q, mcd_flag_q;
  logic             smon_en_q, smon_sel_q, mcd_en_q;

  // ****************************************
  // Request capture
  // ****************************************
  // Own drive and its settling are masked, else the pin would reset us
  assign pin_arst  = rst | (~rst_pin_n_in & ~pin_mask_q);
  assign sup_arst  = rst | (supply_low_in & smon_en_q & smon_sel_q);
  assign async_req = pin_arst | sup_arst;

  // Requests set at once and clear two edges after the source goes away
  rss_sync #(.RST_VAL(1'b1)) u_pin_sync (
    .clk  (sys_clk),
    .arst (pin_arst),
    .d    (1'b0),
    .q    (pin_req)
  );

  rss_sync #(.RST_VAL(1'b1)) u_sup_sync (
    .clk  (sys_clk),
    .arst (sup_arst),
    .d    (1'b0),
    .q    (sup_req)
  );

  // Plain level of the comparator, needed during power-up
  rss_sync #(.RST_VAL(1'b1)) u_low_sync (
    .clk  (sys_clk),
    .arst (rst),
    .d    (supply_low_in),
    .q    (sup_low_s)
  );

  rss_sync #(.RST_VAL(1'b0)) u_probe_sync (
    .clk  (sys_clk),
    .arst (rst),
    .d    (sysclk_probe_in),
    .q    (probe_s)
  );

  // ****************************************
  // Missing clock detector
  // ****************************************
  // Counts cycles since the probed clock last changed level
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      probe_q    <= 1'b0;
      idle_cnt_q <= '0;
    end else begin
      probe_q <= probe_s;
      if (probe_s != probe_q || state_q != ST_RUN) begin
        idle_cnt_q <= '0;
      end else if (idle_cnt_q != CNT_W'(MCD_TIMEOUT_CYCLES)) begin
        idle_cnt_q <= idle_cnt_q + 1'b1;
      end
    end
  end

  assign mcd_trip = mcd_en_q && idle_cnt_q == CNT_W'(MCD_TIMEOUT_CYCLES);

  // ****************************************
  // Sequencer
  // ****************************************
  // Next state and cause of the reset being served
  always_comb begin
    state_d = state_q;
    cause_d = cause_q;
    case (state_q)
      ST_POR_WAIT: begin
        if (!sup_low_s) begin
          state_d = ST_POR_DELAY;
        end
      end
      ST_POR_DELAY: begin
        if (sup_low_s) begin
          state_d = ST_POR_WAIT;
        end else if (cnt_q == CNT_W'(POR_DELAY_CYCLES - 1)) begin
          state_d = ST_SETTLE;
        end
      end
      ST_RUN: begin
        if (sup_req) begin
          state_d = ST_HOLD;
          cause_d = CS_SUP;
        end else if (pin_req) begin
          state_d = ST_HOLD;
          cause_d = CS_PIN;
        end else if (mcd_trip) begin
          state_d = ST_HOLD;
          cause_d = CS_MCD;
        end
      end
      ST_HOLD: begin
        // Supply recovery goes straight to settling, no power-on delay
        if (cause_q == CS_SUP && !sup_req) begin
          state_d = ST_SETTLE;
        end else if (cause_q == CS_PIN && !pin_req) begin
          state_d = ST_SETTLE;
        end else if (cause_q == CS_MCD) begin
          state_d = ST_SETTLE;
        end
      end
      ST_SETTLE: begin
        if (cnt_q == CNT_W'(SETTLE_CYC - 1)) begin
          state_d = ST_RUN;
        end
      end
      default: begin
        state_d = ST_POR_WAIT;
      end
    endcase
  end

  assign in_reset_d = state_d != ST_RUN;
  assign release_d  = state_q != ST_RUN && state_d == ST_RUN;

  // State, cause and the shared delay counter
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      state_q <= ST_POR_WAIT;
      cause_q <= CS_POR;
      cnt_q   <= '0;
    end else begin
      state_q <= state_d;
      cause_q <= cause_d;
      cnt_q   <= (state_d != state_q) ? '0 : cnt_q + 1'b1;
    end
  end

  // ****************************************
  // Reset outputs
  // ****************************************
  // Pin and supply requests raise core reset at once; release waits for an edge
  always_ff @(posedge sys_clk or posedge async_req) begin
    if (async_req) begin
      core_reset_q <= 1'b1;
    end else begin
      core_reset_q <= in_reset_d;
    end
  end

  // Pin driven low only for power-on and supply resets
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      rst_pin_oe_q  <= 1'b1;
      rst_pin_out_q <= 1'b0;
      pin_mask_q    <= 1'b1;
    end else begin
      rst_pin_oe_q  <= state_d == ST_POR_WAIT || state_d == ST_POR_DELAY
                       || (state_d == ST_HOLD && cause_d == CS_SUP);
      rst_pin_out_q <= 1'b0;
      pin_mask_q    <= state_d != ST_RUN && cause_d != CS_PIN;
    end
  end

  // System side effects of entering and leaving reset
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      sfr_load_q    <= 1'b1;
      irq_tmr_off_q <= 1'b1;
      sp_init_q     <= 1'b1;
      port_latch_q  <= PORT_PARK_VAL;
      port_od_q     <= 1'b1;
      pullup_q      <= 1'b1;
      pc_zero_q     <= 1'b0;
      clk_int_q     <= 1'b0;
      wdt_start_q   <= 1'b0;
      wdt_div_q     <= WDT_DIV_VAL;
    end else begin
      sfr_load_q    <= in_reset_d;
      irq_tmr_off_q <= in_reset_d;
      sp_init_q     <= in_reset_d;
      port_latch_q  <= PORT_PARK_VAL;
      port_od_q     <= 1'b1;
      pullup_q      <= 1'b1;
      pc_zero_q     <= release_d;
      clk_int_q     <= release_d;
      wdt_start_q   <= release_d;
      wdt_div_q     <= WDT_DIV_VAL;
    end
  end

  // ****************************************
  // Cause flags and controls
  // ****************************************
  // Flags follow the cause at each exit; they survive all but power-up
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      por_flag_q <= 1'b0;
      pin_flag_q <= 1'b0;
      mcd_flag_q <= 1'b0;
    end else if (release_d) begin
      por_flag_q <= cause_q == CS_POR;
      pin_flag_q <= cause_q == CS_PIN;
      mcd_flag_q <= cause_q == CS_MCD;
    end
  end

  // Software writes are ignored while the core is held
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      smon_en_q  <= SMON_EN_RST;
      smon_sel_q <= SMON_SEL_RST;
      mcd_en_q   <= MCD_EN_RST;
    end else if (reg_wr && !core_reset_q) begin
      if (reg_addr == CAUSE_ADDR) begin
        smon_sel_q <= reg_wdata[POR_FLAG_BIT];
        mcd_en_q   <= reg_wdata[MCD_FLAG_BIT];
      end else if (reg_addr == SMON_ADDR) begin
        smon_en_q <= reg_wdata[SMON_EN_BIT];
      end
    end
  end

  // Read data stand one cycle after the strobe; unmapped reads zero
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      reg_rdata_q <= RD_ZERO;
    end else begin
      reg_rdata_q <= RD_ZERO;
      if (reg_rd) begin
        if (reg_addr == CAUSE_ADDR) begin
          reg_rdata_q[PIN_FLAG_BIT] <= pin_flag_q;
          reg_rdata_q[POR_FLAG_BIT] <= por_flag_q;
          reg_rdata_q[MCD_FLAG_BIT] <= mcd_flag_q;
        end else if (reg_addr == SMON_ADDR) begin
          reg_rdata_q[SMON_EN_BIT]   <= smon_en_q;
          reg_rdata_q[SMON_STAT_BIT] <= ~sup_low_s;
        end
      end
    end
  end

  // ****************************************
  // Assertions
  // ****************************************
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);
  sequence s_release;
    $fell(core_reset_q);
  endsequence
  sequence s_side_pulses;
    pc_zero_q && clk_int_q && wdt_start_q ##1 !pc_zero_q;
  endsequence

  a_core_halted: assert property (
    state_q != ST_RUN |-> core_reset_q)
    else $error("core not halted in reset");

  a_sfr_irq_off: assert property (
    state_q != ST_RUN |-> sfr_load_q && irq_tmr_off_q && sp_init_q)
    else $error("defaults not loaded in reset");

  a_port_parked: assert property (
    port_latch_q == PORT_PARK_VAL && port_od_q && pullup_q)
    else $error("ports not parked");

  a_pin_drive: assert property (
    state_q == ST_POR_WAIT || state_q == ST_POR_DELAY
      || (state_q == ST_HOLD && cause_q == CS_SUP) |-> rst_pin_oe_q && !rst_pin_out_q)
    else $error("pin not driven on power reset");

  a_pin_free_run: assert property (
    state_q == ST_RUN |-> !rst_pin_oe_q)
    else $error("pin driven while running");

  a_exit_steps: assert property (
    s_release |-> s_side_pulses)
    else $error("release pulses missing");

  a_por_delay: assert property (
    state_q == ST_POR_DELAY |-> cnt_q < CNT_W'(POR_DELAY_CYCLES) && !rst_pin_oe_q == 1'b0)
    else $error("power-on delay overrun");

  a_por_flag: assert property (
    s_release ##0 cause_q == CS_POR |-> ##1 por_flag_q)
    else $error("power-on flag not set");

  a_por_clear: assert property (
    s_release ##0 cause_q != CS_POR |-> ##1 !por_flag_q)
    else $error("power-on flag not cleared");

  a_pin_flag: assert property (
    s_release ##0 cause_q == CS_PIN |-> ##1 pin_flag_q && !mcd_flag_q)
    else $error("pin flag not set");

  a_mcd_trip: assert property (
    state_q == ST_RUN && !sup_req && !pin_req && mcd_trip |=> state_q == ST_HOLD
      ##1 state_q == ST_SETTLE)
    else $error("missing clock reset not taken");

  a_smon_kept: assert property (
    state_q == ST_HOLD |=> $stable(smon_en_q))
    else $error("supply monitor enable changed");

  a_sup_fast: assert property (
    state_q == ST_HOLD && cause_q == CS_SUP && !sup_req |=> state_q == ST_SETTLE
      ##[1:8] state_q == ST_RUN)
    else $error("supply release delayed");

endmodule : rss_top

//--- bench/rss_pin_model.sv
`timescale 1ns/100ps
// ****************************************
// Reset pin wire with external pull-up
// ****************************************
module rss_pin_model (
  // Device drive
  input  wire logic drv_out,
  input  wire logic drv_oe,
  // Outside circuitry pulling the pin low
  input  wire logic ext_low,
  // Resolved pin level
  output logic      pin_level
);
  // Open-drain wire: any low drive wins, the pull-up sets the idle level
  assign pin_level = !(ext_low || (drv_oe && !drv_out));
endmodule : rss_pin_model

//--- bench/rss_top_tb.sv
`timescale 1ns/100ps
module rss_top_tb;
  import rss_pkg::*;
  // ****************************************
  // Signals
  // ****************************************
  localparam int PD = 20;  // Shortened release delay
  localparam int MT = 16;  // Shortened missing clock timeout
  logic       sys_clk = 1'b0;
  logic       rst = 1'b1;
  logic       supply_low_in = 1'b1;
  logic       rst_pin_n_in;
  logic       sysclk_probe_in = 1'b0;
  logic       rst_pin_out_q, rst_pin_oe_q, ext_low = 1'b0, probe_run = 1'b1;
  logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata_q;
  logic       reg_wr = 1'b0, reg_rd = 1'b0;
  logic       core_reset_q, sfr_load_q, irq_tmr_off_q, sp_init_q, port_od_q, pullup_q;
  logic       pc_zero_q, clk_int_q, wdt_start_q;
  logic [7:0] port_latch_q;
  logic [3:0] wdt_div_q;
  logic [7:0] x = 8'h1D;
  int         bad_count = 0, tests_run = 0, n;

  always #10 sys_clk = ~sys_clk;
  // Probe toggles every cycle unless a scenario stalls it
  always @(posedge sys_clk) if (probe_run) sysclk_probe_in <= ~sysclk_probe_in;

  rss_top #(.POR_DELAY_CYCLES(PD), .MCD_TIMEOUT_CYCLES(MT)) rss_top_i (
    .sys_clk(sys_clk), .rst(rst), .supply_low_in(supply_low_in),
    .rst_pin_n_in(rst_pin_n_in), .sysclk_probe_in(sysclk_probe_in),
    .rst_pin_out_q(rst_pin_out_q), .rst_pin_oe_q(rst_pin_oe_q),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata_q(reg_rdata_q), .core_reset_q(core_reset_q), .sfr_load_q(sfr_load_q),
    .irq_tmr_off_q(irq_tmr_off_q), .sp_init_q(sp_init_q), .port_latch_q(port_latch_q),
    .port_od_q(port_od_q), .pullup_q(pullup_q), .pc_zero_q(pc_zero_q),
    .clk_int_q(clk_int_q), .wdt_start_q(wdt_start_q), .wdt_div_q(wdt_div_q));

  rss_pin_model rss_pin_model_i (
    .drv_out(rst_pin_out_q), .drv_oe(rst_pin_oe_q), .ext_low(ext_low),
    .pin_level(rst_pin_n_in));

  // ****************************************
  // Helpers
  // ****************************************
  function automatic logic [7:0] lfsr(input logic [7:0] v);
    return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
  endfunction : lfsr

  // Expected cause register for a flag position, others zero
  function automatic logic [7:0] cause_of(input int bit_pos);
    return 8'h01 << bit_pos;
  endfunction : cause_of

  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    tests_run++;
    if (seen !== exp) begin
      bad_count++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
  endtask : wr

  // Read data stand only in the cycle after the strobe
  task automatic rd(input logic [7:0] a, input logic [7:0] m, input logic [7:0] exp);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    #1 chk(reg_rdata_q & m, exp);
  endtask : rd

  task automatic hold_chk;
    chk({core_reset_q, sfr_load_q, irq_tmr_off_q, sp_init_q, 4'hF}, 8'hFF);
    chk({port_od_q, pullup_q, 6'h3F}, 8'hFF);
    chk(port_latch_q, PORT_PARK_VAL);
  endtask : hold_chk

  // Counts cycles until release, then checks the release pulses
  task automatic wait_release(output int cnt);
    cnt = 0;
    while (core_reset_q === 1'b1 && cnt < 400) begin
      @(posedge sys_clk);
      #1 cnt++;
    end
    chk({pc_zero_q, clk_int_q, wdt_start_q, 1'b0, wdt_div_q}, 8'hEC);
    chk({port_od_q, pullup_q, port_latch_q[0], 5'h00}, 8'hE0);
  endtask : wait_release

  task automatic end_of_test;
    $display("Comparisons %0d, mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : end_of_test

  // ****************************************
  // Scenarios
  // ****************************************
  initial begin
    repeat (3) @(posedge sys_clk);
    rst <= 1'b0;
    #1 hold_chk;
    chk({7'h00, rst_pin_oe_q}, 8'h01);
    // Supply still below threshold: release must wait for it
    repeat (10) @(posedge sys_clk);
    supply_low_in <= 1'b0;
    #1 chk({7'h00, core_reset_q}, 8'h01);
    wait_release(n);
    chk({7'h00, n >= PD}, 8'h01);
    rd(CAUSE_ADDR, cause_of(POR_FLAG_BIT), cause_of(POR_FLAG_BIT));
    rd(SMON_ADDR, 8'hC0, 8'hC0);
    // Random traffic to unmapped places reads back zero
    for (int i = 0; i < 6; i++) begin
      x = lfsr(x);
      wr(x | 8'h10, lfsr(x));
      rd(x | 8'h10, 8'hFF, RD_ZERO);
    end
    // Missing clock: enable detector, keep supply selected, stall probe
    wr(CAUSE_ADDR, 8'h06);
    probe_run <= 1'b0;
    n = 0;
    while (core_reset_q !== 1'b1 && n < MT + 10) begin
      @(posedge sys_clk);
      #1 n++;
    end
    chk({core_reset_q, rst_pin_oe_q, 6'h00}, 8'h80);
    probe_run <= 1'b1;
    wait_release(n);
    rd(CAUSE_ADDR, 8'h07, cause_of(MCD_FLAG_BIT));
    // Detector off: a stalled probe does nothing
    wr(CAUSE_ADDR, 8'h02);
    probe_run <= 1'b0;
    repeat (MT + 8) @(posedge sys_clk);
    #1 chk({7'h00, core_reset_q}, 8'h00);
    probe_run <= 1'b1;
    // Monitor disabled by software: low supply is ignored
    x = lfsr(x);
    wr(SMON_ADDR, x & 8'h7F);
    supply_low_in <= 1'b1;
    repeat (8) @(posedge sys_clk);
    #1 chk({7'h00, core_reset_q}, 8'h00);
    rd(SMON_ADDR, 8'hC0, 8'h00);
    @(posedge sys_clk);
    supply_low_in <= 1'b0;
    repeat (4) @(posedge sys_clk);
    // Pin reset enters at once, without self drive
    ext_low <= 1'b1;
    #1 chk({core_reset_q, rst_pin_oe_q, 6'h00}, 8'h80);
    // Side outputs follow the state, one edge after the asynchronous halt
    @(posedge sys_clk);
    #1 hold_chk;
    chk({core_reset_q, rst_pin_oe_q, 6'h00}, 8'h80);
    repeat (3) @(posedge sys_clk);
    ext_low <= 1'b0;
    wait_release(n);
    rd(CAUSE_ADDR, 8'h07, cause_of(PIN_FLAG_BIT));
    rd(SMON_ADDR, 8'h80, 8'h00);
    // Supply reset drives the pin and skips the release delay
    wr(SMON_ADDR, 8'h80);
    supply_low_in <= 1'b1;
    repeat (4) @(posedge sys_clk);
    #1 chk({core_reset_q, rst_pin_oe_q, rst_pin_n_in, 5'h00}, 8'hC0);
    hold_chk;
    @(posedge sys_clk);
    supply_low_in <= 1'b0;
    wait_release(n);
    chk({7'h00, n < PD}, 8'h01);
    rd(CAUSE_ADDR, 8'h07, 8'h00);
    rd(SMON_ADDR, 8'h80, 8'h80);
    // Power-on reset in mid-run brings a software-disabled monitor back
    wr(SMON_ADDR, 8'h00);
    rst <= 1'b1;
    repeat (3) @(posedge sys_clk);
    rst <= 1'b0;
    #1 hold_chk;
    chk({7'h00, rst_pin_oe_q}, 8'h01);
    wait_release(n);
    chk({7'h00, n >= PD}, 8'h01);
    rd(CAUSE_ADDR, cause_of(POR_FLAG_BIT), cause_of(POR_FLAG_BIT));
    rd(SMON_ADDR, 8'h80, 8'h80);
    end_of_test;
  end

  // Whole run is a few hundred cycles; cut a hang short
  initial begin
    #400000;
    bad_count++;
    end_of_test;
  end
endmodule : rss_top_tb
